// *** rtl/acr_reg_bank.sv ***
// serial-loaded calibration and output configuration registers
`timescale 1ns/100ps
module acr_reg_bank (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_EXT_CONTROL_MODE,
    input wire logic I_SERIAL_CLK,
    input wire logic I_SERIAL_SELECT_N,
    input wire logic I_SERIAL_DATA_IN,
    output logic O_CALIBRATION_START,
    output logic O_SECOND_OUT_CLOCK_ENABLE_N,
    output logic O_DUTY_CYCLE_STABILIZER_ENABLE,
    output logic O_DOUBLE_RATE_CLOCK_PHASE_SELECT,
    output logic O_DATA_OUTPUT_CLOCK_PHASE_90,
    output logic O_FRAME_ERROR
);
    import acr_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic sclk_rise;
    logic sel_n;
    logic ser_bit;
    logic ext_mode;

    acr_pin_sync u_sync_clk (
        .i_clk(I_SYS_CLK), .i_rst_n(I_RESETN), .i_ce(I_CE), .i_pin(I_SERIAL_CLK),
        .i_reset_val(1'b0), .o_level(), .o_rise(sclk_rise)
    );
    acr_pin_sync u_sync_sel (
        .i_clk(I_SYS_CLK), .i_rst_n(I_RESETN), .i_ce(I_CE), .i_pin(I_SERIAL_SELECT_N),
        .i_reset_val(1'b1), .o_level(sel_n), .o_rise()
    );
    acr_pin_sync u_sync_dat (
        .i_clk(I_SYS_CLK), .i_rst_n(I_RESETN), .i_ce(I_CE), .i_pin(I_SERIAL_DATA_IN),
        .i_reset_val(1'b0), .o_level(ser_bit), .o_rise()
    );
    acr_pin_sync u_sync_mode (
        .i_clk(I_SYS_CLK), .i_rst_n(I_RESETN), .i_ce(I_CE), .i_pin(I_EXT_CONTROL_MODE),
        .i_reset_val(1'b0), .o_level(ext_mode), .o_rise()
    );

    // ****************************************
    // frame shifter state
    // ****************************************
    acr_state_e state;
    acr_state_e next_state;
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit_cnt;
    logic [15:0] cal_reg;
    logic [15:0] next_cal_reg;
    logic [15:0] cfg_reg;
    logic [15:0] next_cfg_reg;
    logic cal_pulse;
    logic next_cal_pulse;
    logic frame_err;
    logic next_frame_err;
    logic serial_take;

    // serial port live only in extended mode with select low
    assign serial_take = sclk_rise & ~sel_n & ext_mode;

    // shift on each serial rise, commit at the 32nd bit
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_cal_reg = cal_reg;
        next_cfg_reg = cfg_reg;
        next_cal_pulse = 1'b0;
        next_frame_err = frame_err;
        case (state)
            ST_IDLE: begin
                next_bit_cnt = 6'h00;
                if (serial_take) begin
                    next_shreg = {shreg[FRAME_BITS-2:0], ser_bit};
                    next_bit_cnt = 6'h01;
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sel_n || !ext_mode) begin
                    next_state = ST_IDLE; // partial frame dropped
                    next_frame_err = 1'b1;
                end else if (serial_take) begin
                    next_shreg = {shreg[FRAME_BITS-2:0], ser_bit};
                    next_bit_cnt = bit_cnt + 6'h01;
                    if (bit_cnt == FRAME_LAST) begin
                        next_state = ST_COMMIT;
                    end
                end
            end
            ST_COMMIT: begin
                // next frame starts on the 33rd clock, no select release
                next_bit_cnt = 6'h00;
                next_state = ST_IDLE;
                if (shreg[HDR_MSB:HDR_LSB] != FRAME_HEADER) begin
                    next_frame_err = 1'b1;
                end else begin
                    next_frame_err = 1'b0;
                    case (shreg[ADDR_MSB:ADDR_LSB])
                        ADDR_CALIBRATION_TRIGGER: begin
                            next_cal_reg = shreg[DATA_MSB:0];
                            next_cal_pulse = shreg[BIT_CAL_START];
                        end
                        ADDR_OUTPUT_CONFIGURATION: begin
                            next_cfg_reg = shreg[DATA_MSB:0];
                        end
                        default: begin
                            next_cfg_reg = cfg_reg; // other seven held elsewhere
                        end
                    endcase
                end
                if (serial_take) begin
                    next_shreg = {shreg[FRAME_BITS-2:0], ser_bit};
                    next_bit_cnt = 6'h01;
                    next_state = ST_SHIFT;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // registers only, no read path exists
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state <= ST_IDLE;
            shreg <= '0;
            bit_cnt <= 6'h00;
            cal_reg <= RST_CALIBRATION_TRIGGER;
            cfg_reg <= RST_OUTPUT_CONFIGURATION;
            cal_pulse <= 1'b0;
            frame_err <= 1'b0;
        end else if (I_CE) begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            cal_reg <= next_cal_reg;
            cfg_reg <= next_cfg_reg;
            cal_pulse <= next_cal_pulse;
            frame_err <= next_frame_err;
        end
    end

    // ****************************************
    // control outputs
    // ****************************************
    logic next_sd_n;
    logic next_stab_en;
    logic next_phase_sel;
    logic next_ph90;

    // in normal mode the defaults stand in for the register contents
    always_comb begin
        next_sd_n = RST_OUTPUT_CONFIGURATION[BIT_SECOND_CLK_N];
        next_stab_en = RST_OUTPUT_CONFIGURATION[BIT_DUTY_STAB];
        next_phase_sel = RST_OUTPUT_CONFIGURATION[BIT_DDR_PHASE];
        if (ext_mode) begin
            next_sd_n = cfg_reg[BIT_SECOND_CLK_N];
            next_stab_en = cfg_reg[BIT_DUTY_STAB];
            next_phase_sel = cfg_reg[BIT_DDR_PHASE];
        end
        // phase honoured only in ddr clocking, else 0 degree
        next_ph90 = next_phase_sel & ~(ext_mode ? cfg_reg[BIT_DDR_ENABLE_N] : 1'b0);
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_CALIBRATION_START <= 1'b0;
            O_SECOND_OUT_CLOCK_ENABLE_N <= RST_OUTPUT_CONFIGURATION[BIT_SECOND_CLK_N];
            O_DUTY_CYCLE_STABILIZER_ENABLE <= RST_OUTPUT_CONFIGURATION[BIT_DUTY_STAB];
            O_DOUBLE_RATE_CLOCK_PHASE_SELECT <= RST_OUTPUT_CONFIGURATION[BIT_DDR_PHASE];
            O_DATA_OUTPUT_CLOCK_PHASE_90 <= 1'b0;
            O_FRAME_ERROR <= 1'b0;
        end else if (I_CE) begin
            O_CALIBRATION_START <= cal_pulse;
            O_SECOND_OUT_CLOCK_ENABLE_N <= next_sd_n;
            O_DUTY_CYCLE_STABILIZER_ENABLE <= next_stab_en;
            O_DOUBLE_RATE_CLOCK_PHASE_SELECT <= next_phase_sel;
            O_DATA_OUTPUT_CLOCK_PHASE_90 <= next_ph90;
            O_FRAME_ERROR <= frame_err;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    a_cal_pulse_width: assert property (O_CALIBRATION_START && I_CE |=> !O_CALIBRATION_START)
        else $error("calibration start longer than one cycle");
    a_cal_needs_bit: assert property (I_CE && cal_pulse |-> cal_reg[BIT_CAL_START])
        else $error("calibration start without bit 15");
    a_normal_defaults: assert property (I_CE && !ext_mode ##1 I_CE && !ext_mode |=>
        O_SECOND_OUT_CLOCK_ENABLE_N && O_DUTY_CYCLE_STABILIZER_ENABLE)
        else $error("register setting leaked in normal mode");
    a_sd_follows_reg: assert property (I_CE && ext_mode |=> I_CE |->
        O_SECOND_OUT_CLOCK_ENABLE_N == $past(cfg_reg[BIT_SECOND_CLK_N]))
        else $error("second clock enable not following register");
    a_stab_follows_reg: assert property (I_CE && ext_mode |=> I_CE |->
        O_DUTY_CYCLE_STABILIZER_ENABLE == $past(cfg_reg[BIT_DUTY_STAB]))
        else $error("stabilizer not following register");
    a_phase_sdr_zero: assert property (I_CE && ext_mode && cfg_reg[BIT_DDR_ENABLE_N] |=>
        !I_CE || !O_DATA_OUTPUT_CLOCK_PHASE_90)
        else $error("90 degree phase outside ddr clocking");
    a_phase_zero_sel: assert property (O_DATA_OUTPUT_CLOCK_PHASE_90 |->
        O_DOUBLE_RATE_CLOCK_PHASE_SELECT)
        else $error("90 degree phase with select zero");
    a_phase_ninety: assert property (I_CE && ext_mode && cfg_reg[BIT_DDR_PHASE]
        && !cfg_reg[BIT_DDR_ENABLE_N] |=> !I_CE || O_DATA_OUTPUT_CLOCK_PHASE_90)
        else $error("90 degree phase not applied");
    a_commit_after_32: assert property (state == ST_COMMIT |-> $past(bit_cnt) == FRAME_LAST)
        else $error("frame committed at wrong bit count");
    a_no_take_idle_mode: assert property (!ext_mode && state == ST_IDLE && I_CE |=>
        state == ST_IDLE)
        else $error("frame accepted in normal mode");

    c_cal_start: cover property (O_CALIBRATION_START);
    c_back_to_back: cover property (state == ST_COMMIT ##[1:40] state == ST_SHIFT);
    c_frame_error: cover property (O_FRAME_ERROR);
    c_phase_90: cover property (O_DATA_OUTPUT_CLOCK_PHASE_90);
endmodule : acr_reg_bank

// *** rtl/acr_pkg.sv ***
// constants and types of the converter control register bank
package acr_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_LAST = 6'h1f;
    localparam logic [11:0] FRAME_HEADER = 12'h001;
    localparam int HDR_MSB = 31;
    localparam int HDR_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;

    // ****************************************
    // register addresses and reset values
    // ****************************************
    localparam logic [3:0] ADDR_CALIBRATION_TRIGGER = 4'h0;
    localparam logic [3:0] ADDR_OUTPUT_CONFIGURATION = 4'h1;
    localparam logic [15:0] RST_CALIBRATION_TRIGGER = 16'h7fff;
    localparam logic [15:0] RST_OUTPUT_CONFIGURATION = 16'hb2ff;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_CAL_START = 15;
    localparam int BIT_SECOND_CLK_N = 13;
    localparam int BIT_DUTY_STAB = 12;
    localparam int BIT_DDR_PHASE = 11;
    localparam int BIT_DDR_ENABLE_N = 10;

    // ****************************************
    // clock and pulse timing
    // ****************************************
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int CAL_PULSE_NS = 8;
    localparam int CAL_PULSE_CYCLES =
        (CAL_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_COMMIT} acr_state_e;
endpackage : acr_pkg

// *** rtl/acr_pin_sync.sv ***
// two-stage synchroniser with rise detect for the serial pins
`timescale 1ns/100ps
module acr_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pin,
    input wire logic i_reset_val,
    output logic o_level,
    output logic o_rise
);
    import acr_pkg::*;
    logic meta;
    logic sync;
    logic prev;
    logic level;
    logic [1:0] fill;
    logic next_meta;
    logic next_sync;
    logic next_prev;
    logic [1:0] next_fill;

    // ****************************************
    // sampling chain
    // ****************************************
    // idle level stands until the chain holds real pin samples
    assign level = fill[1] ? sync : i_reset_val;

    // meta feeds only sync; fill counts the chain up after reset
    always_comb begin
        next_meta = i_ce ? i_pin : meta;
        next_sync = i_ce ? meta : sync;
        next_prev = i_ce ? level : prev;
        next_fill = i_ce ? {fill[0], 1'b1} : fill;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            fill <= 2'b00;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
            fill <= next_fill;
        end
    end

    // no false edge while the chain fills after reset
    assign o_level = level;
    assign o_rise = fill[1] & level & ~prev;
endmodule : acr_pin_sync

// *** verif/acr_host_model.sv ***
// host controller model driving the three-wire serial port
`timescale 1ns/100ps
module acr_host_model (
    input wire logic i_clk,
    output logic o_sclk,
    output logic o_select_n,
    output logic o_data
);
    // idle port: serial clock still, select released
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_data = 1'b0;
    end

    // shift n bits msb first at a 125 ns serial clock, edges kept off system clock edges
    task automatic send_bits(input logic [31:0] frame, input int n);
        @(posedge i_clk);
        #0.2;
        for (int i = 31; i > 31 - n; i--) begin
            o_select_n <= 1'b0;
            o_data <= frame[i];
            #62.5;
            o_sclk <= 1'b1;
            #62.5;
            o_sclk <= 1'b0;
        end
    endtask : send_bits

    // release select; the undriven data line shows the inverse of its last bit
    task automatic release_port();
        o_select_n <= 1'b1;
        o_data <= ~o_data;
        repeat (2) @(posedge i_clk);
    endtask : release_port
endmodule : acr_host_model

// *** verif/acr_reg_bank_tb_top.sv ***
// self-checking bench for the serial-loaded register bank
`timescale 1ns/100ps
module acr_reg_bank_tb_top;
    import acr_pkg::*;
    logic clk, rst_n, ce, ext_mode, sclk, sel_n, sdin;
    logic cal, sd_n, stab, phase, p90, ferr;
    int n_errors = 0;
    int num_checks = 0;
    int n_cal = 0;
    logic [3:0] init_addr [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
    logic [15:0] cfg_val [3] = '{16'h8aff, 16'hbeff, 16'hb2ff};
    logic [4:0] cfg_exp [3] = '{5'h06, 5'h1c, 5'h18};

    // system clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    acr_reg_bank u_dut (
        .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_EXT_CONTROL_MODE(ext_mode),
        .I_SERIAL_CLK(sclk), .I_SERIAL_SELECT_N(sel_n), .I_SERIAL_DATA_IN(sdin),
        .O_CALIBRATION_START(cal), .O_SECOND_OUT_CLOCK_ENABLE_N(sd_n),
        .O_DUTY_CYCLE_STABILIZER_ENABLE(stab), .O_DOUBLE_RATE_CLOCK_PHASE_SELECT(phase),
        .O_DATA_OUTPUT_CLOCK_PHASE_90(p90), .O_FRAME_ERROR(ferr)
    );

    acr_host_model u_host (.i_clk(clk), .o_sclk(sclk), .o_select_n(sel_n), .o_data(sdin));

    // count cycles with the calibration pulse high
    always @(posedge clk) begin
        if (cal === 1'b1) n_cal++;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_outs(input logic [4:0] exp);
        check({27'h0, sd_n, stab, phase, p90, ferr}, {27'h0, exp});
    endtask : check_outs

    // one whole frame, select stays low afterwards
    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        u_host.send_bits({FRAME_HEADER, addr, data}, 32);
        repeat (8) @(posedge clk);
    endtask : wr

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        ext_mode = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_outs(5'h18);
        ext_mode <= 1'b1;
        repeat (8) @(posedge clk);
        // first use: all nine registers back to back without select release
        foreach (init_addr[i]) begin
            wr(init_addr[i], (i == 0) ? RST_CALIBRATION_TRIGGER :
               (i == 1) ? RST_OUTPUT_CONFIGURATION : 16'h007f);
        end
        check_outs(5'h18);
        check(n_cal, 0);
        // configuration field table
        foreach (cfg_val[i]) begin
            wr(ADDR_OUTPUT_CONFIGURATION, cfg_val[i]);
            check_outs(cfg_exp[i]);
        end
        // normal mode hides settings, extended mode restores them
        wr(ADDR_OUTPUT_CONFIGURATION, 16'h8aff);
        u_host.release_port();
        ext_mode <= 1'b0;
        repeat (8) @(posedge clk);
        check_outs(5'h18);
        ext_mode <= 1'b1;
        repeat (8) @(posedge clk);
        check_outs(5'h06);
        // calibration start gives one single-cycle pulse
        wr(ADDR_CALIBRATION_TRIGGER, 16'hffff);
        u_host.release_port();
        check(n_cal, CAL_PULSE_CYCLES);
        check_outs(5'h06);
        // wrong header is refused
        u_host.send_bits({12'h002, ADDR_OUTPUT_CONFIGURATION, 16'hb2ff}, 32);
        u_host.release_port();
        repeat (8) @(posedge clk);
        check_outs(5'h07);
        wr(ADDR_OUTPUT_CONFIGURATION, 16'hb2ff);
        check_outs(5'h18);
        // select released mid-frame drops the partial frame
        u_host.send_bits({FRAME_HEADER, ADDR_OUTPUT_CONFIGURATION, 16'h8aff}, 16);
        u_host.release_port();
        repeat (8) @(posedge clk);
        check_outs(5'h19);
        wr(ADDR_OUTPUT_CONFIGURATION, 16'h8aff);
        u_host.release_port();
        check_outs(5'h06);
        // clock enable low freezes the outputs through a mode change
        ce <= 1'b0;
        ext_mode <= 1'b0;
        repeat (8) @(posedge clk);
        check_outs(5'h06);
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        check_outs(5'h18);
        ext_mode <= 1'b1;
        repeat (8) @(posedge clk);
        check_outs(5'h06);
        // reset in extended mode reloads the register defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_outs(5'h18);
        summarize();
    end

    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule : acr_reg_bank_tb_top
